// ### design/timer_defs.svh
// Register offsets, field positions and reset values of the three timers.
// Assumes an 8-bit register port with the printed byte offsets.
// Behaviour
// - Clock select 1 uses CPU clock, else 32 kHz.
// - Start clear holds the counter in reset.
// - Start set loads 16-bit value, counts down.
// - Continuous mode reloads at every terminal count.
// - One-shot runs one period, then clears start.
// - High byte is bits 15:8, low 7:0.
// - Count bytes read/write, reset to zero.
// - Config bits: clock select 2, one-shot 1, start 0.
// - Three independent timers, each with own registers.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define T0_CONFIG_OFS 8'hb0
`define T0_HIGH_OFS 8'hb1
`define T0_LOW_OFS 8'hb2
`define T1_CONFIG_OFS 8'hb3
`define T1_HIGH_OFS 8'hb4
`define T1_LOW_OFS 8'hb5
`define T2_CONFIG_OFS 8'hb6
`define T2_HIGH_OFS 8'hb7
`define T2_LOW_OFS 8'hb8
`define IRQ_STATUS_OFS 8'hc0
`define IRQ_MASK_OFS 8'hc1

`define CFG_START_BIT 0
`define CFG_ONE_SHOT_BIT 1
`define CFG_CLK_SEL_BIT 2

`define CFG_RESET 3'h0
`define COUNT_RESET 8'h00
`define CNT_RESET 16'h0000
`define IRQ_RESET 3'h0

`endif

// ### design/timer_pkg.sv
// Types shared by the timer block.
// Assumes the constants header supplies offsets and field positions.
package timer_pkg;

	typedef struct packed {
		logic clk_sel;
		logic one_shot;
		logic start;
	} timer_cfg_t;

	typedef logic [15:0] timer_count_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wr_data;
		logic wr_en;
	} reg_wr_t;

endpackage

// ### design/triple_programmable_down_timer.sv
// Three 16-bit down-counting timers with a plain register port.
// Assumes slow_clk is a free-running 32 kHz clock from another domain.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "timer_defs.svh"

module triple_programmable_down_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow_clk,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	output logic irq,
	output logic [2:0] tc_event
);

	logic slow_meta_q;
	logic slow_sync_q;
	logic slow_prev_q;
	logic [7:0] rd_data_q;
	logic irq_q;
	logic [2:0] tc_q;
	logic [2:0] status_q;
	logic [2:0] mask_q;
	timer_pkg::reg_wr_t bus_wr;
	logic [7:0] rd_data_d;

	wire slow_tick;
	wire [2:0] tc_now;
	wire [7:0] rd_part [3];
	wire status_hit;
	wire mask_hit;
	wire [2:0] status_d;
	wire [2:0] mask_d;
	wire [7:0] rd_mux;

	// The slow clock passes two flip-flops; its rising edge makes a tick.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slow_meta_q <= 1'b0;
			slow_sync_q <= 1'b0;
			slow_prev_q <= 1'b0;
		end else begin
			slow_meta_q <= slow_clk;
			slow_sync_q <= slow_meta_q;
			slow_prev_q <= slow_sync_q;
		end
	end

	assign slow_tick = slow_sync_q & ~slow_prev_q;

	assign bus_wr = {addr, wr_data, wr_en};

	down_timer_unit #(
		.CFG_ADDR(`T0_CONFIG_OFS),
		.HIGH_ADDR(`T0_HIGH_OFS),
		.LOW_ADDR(`T0_LOW_OFS)
	) u_down_timer_unit_0 (
		.clk(clk),
		.rst(rst),
		.slow_tick(slow_tick),
		.bus_wr(bus_wr),
		.rd_addr(addr),
		.rd_part(rd_part[0]),
		.tc_now(tc_now[0])
	);

	down_timer_unit #(
		.CFG_ADDR(`T1_CONFIG_OFS),
		.HIGH_ADDR(`T1_HIGH_OFS),
		.LOW_ADDR(`T1_LOW_OFS)
	) u_down_timer_unit_1 (
		.clk(clk),
		.rst(rst),
		.slow_tick(slow_tick),
		.bus_wr(bus_wr),
		.rd_addr(addr),
		.rd_part(rd_part[1]),
		.tc_now(tc_now[1])
	);

	down_timer_unit #(
		.CFG_ADDR(`T2_CONFIG_OFS),
		.HIGH_ADDR(`T2_HIGH_OFS),
		.LOW_ADDR(`T2_LOW_OFS)
	) u_down_timer_unit_2 (
		.clk(clk),
		.rst(rst),
		.slow_tick(slow_tick),
		.bus_wr(bus_wr),
		.rd_addr(addr),
		.rd_part(rd_part[2]),
		.tc_now(tc_now[2])
	);

	assign status_hit = wr_en && (addr == `IRQ_STATUS_OFS);
	assign mask_hit = wr_en && (addr == `IRQ_MASK_OFS);
	// A new event wins over a write-one clear in the same cycle.
	assign status_d = (status_q & ~(status_hit ? wr_data[2:0] : 3'h0)) |
		tc_now;
	assign mask_d = mask_hit ? wr_data[2:0] : mask_q;
	assign rd_mux = rd_part[0] | rd_part[1] | rd_part[2] |
		((addr == `IRQ_STATUS_OFS) ? {5'h00, status_q} : 8'h00) |
		((addr == `IRQ_MASK_OFS) ? {5'h00, mask_q} : 8'h00);

	assign rd_data_d = rd_en ? rd_mux : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= `IRQ_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask_q <= `IRQ_RESET;
		end else begin
			mask_q <= mask_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_d & mask_d);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tc_q <= `IRQ_RESET;
		end else begin
			tc_q <= tc_now;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= 8'h00;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	assign rd_data = rd_data_q;
	assign irq = irq_q;
	assign tc_event = tc_q;

endmodule

// One programmable down timer with its own register triple.
module down_timer_unit #(
	parameter logic [7:0] CFG_ADDR = 8'h00,
	parameter logic [7:0] HIGH_ADDR = 8'h01,
	parameter logic [7:0] LOW_ADDR = 8'h02
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow_tick,
	input wire timer_pkg::reg_wr_t bus_wr,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_part,
	output logic tc_now
);

	timer_pkg::timer_cfg_t cfg_q;
	timer_pkg::timer_cfg_t cfg_d;
	logic [7:0] high_q;
	logic [7:0] high_d;
	logic [7:0] low_q;
	logic [7:0] low_d;
	timer_pkg::timer_count_t cnt_q;
	timer_pkg::timer_count_t cnt_d;
	logic armed_q;
	logic armed_d;

	wire cfg_hit;
	wire high_hit;
	wire low_hit;
	wire tick;
	wire at_zero;
	wire at_tc;
	wire hw_stop;
	wire [7:0] cfg_byte;
	wire [7:0] cfg_part;
	wire [7:0] high_part;
	wire [7:0] low_part;
	timer_pkg::timer_count_t reload;
	timer_pkg::timer_count_t count_less;
	timer_pkg::timer_cfg_t cfg_wr;

	assign cfg_hit = bus_wr.wr_en && (bus_wr.addr == CFG_ADDR);
	assign high_hit = bus_wr.wr_en && (bus_wr.addr == HIGH_ADDR);
	assign low_hit = bus_wr.wr_en && (bus_wr.addr == LOW_ADDR);

	assign tick = cfg_q.clk_sel | slow_tick;
	assign reload = {high_q, low_q};
	assign count_less = cnt_q - 16'h0001;
	assign at_zero = (cnt_q == 16'h0000);
	assign at_tc = cfg_q.start && armed_q && tick && at_zero;
	assign tc_now = at_tc;
	assign hw_stop = at_tc && cfg_q.one_shot;

	assign cfg_wr.clk_sel = bus_wr.wr_data[`CFG_CLK_SEL_BIT];
	assign cfg_wr.one_shot = bus_wr.wr_data[`CFG_ONE_SHOT_BIT];
	assign cfg_wr.start = bus_wr.wr_data[`CFG_START_BIT];

	assign high_d = high_hit ? bus_wr.wr_data : high_q;
	assign low_d = low_hit ? bus_wr.wr_data : low_q;

	assign cfg_byte = {5'h00, cfg_q};
	assign cfg_part = (rd_addr == CFG_ADDR) ? cfg_byte : 8'h00;
	assign high_part = (rd_addr == HIGH_ADDR) ? high_q : 8'h00;
	assign low_part = (rd_addr == LOW_ADDR) ? low_q : 8'h00;
	assign rd_part = cfg_part | high_part | low_part;

	always_comb begin
		cfg_d = cfg_q;
		if (cfg_hit) begin
			cfg_d = cfg_wr;
		end else if (hw_stop) begin
			cfg_d.start = 1'b0;
		end
	end

	always_comb begin
		cnt_d = cnt_q;
		armed_d = armed_q;
		if (!cfg_q.start) begin
			cnt_d = `CNT_RESET;
			armed_d = 1'b0;
		end else if (!armed_q) begin
			cnt_d = reload;
			armed_d = 1'b1;
		end else if (at_tc) begin
			cnt_d = reload;
		end else if (tick) begin
			cnt_d = count_less;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= `CFG_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			high_q <= `COUNT_RESET;
		end else begin
			high_q <= high_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			low_q <= `COUNT_RESET;
		end else begin
			low_q <= low_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= `CNT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= armed_d;
		end
	end
endmodule

// ### tb/timer_port_checker.sv
// Port checks for the triple down timer.
// Assumes it is bound to the timer top module.
`timescale 1ns/1ps
module timer_port_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow_clk,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rd_data,
	input wire logic irq,
	input wire logic [2:0] tc_event
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_rdz; !$past(rd_en) |-> rd_data == 8'h00; endproperty
	a_rdz: assert property (p_rdz) else $error("read idle");
	property p_msk; wr_en && addr == 8'hc1 && wr_data == 8'h00 |=> ##1 !irq;
	endproperty
	a_msk: assert property (p_msk) else $error("mask");
	property p_stp; wr_en && addr == 8'hb3 && !wr_data[0] |=>
		##1 !tc_event[1] [*2]; endproperty
	a_stp: assert property (p_stp) else $error("stop");
	property p_tc1; tc_event[1] |=> !tc_event[1]; endproperty
	a_tc1: assert property (p_tc1) else $error("pulse");
	property p_tc2; $rose(tc_event[2]) |=> $fell(tc_event[2]); endproperty
	a_tc2: assert property (p_tc2) else $error("pulse two");
	property p_cfg; rd_en && addr == 8'hb3 |=> rd_data[7:3] == 5'h00;
	endproperty
	a_cfg: assert property (p_cfg) else $error("config");
	property p_map; rd_en && addr == 8'hb9 |=> rd_data == 8'h00; endproperty
	a_map: assert property (p_map) else $error("unmapped");
	property p_rbk; wr_en && addr == 8'hb1 ##1 rd_en && addr == 8'hb1 |=>
		rd_data == $past(wr_data, 2); endproperty
	a_rbk: assert property (p_rbk) else $error("readback");
	c_tc0: cover property (tc_event[0]);
	c_irq: cover property ($rose(irq));
	c_tc2: cover property (tc_event[2]);
endmodule
bind triple_programmable_down_timer timer_port_checker u_timer_port_checker (.*);

// ### tb/triple_programmable_down_timer_tb_top.sv
// Self-checking bench for the three down timers.
// Assumes design and checker files are compiled first.
`timescale 1ns/1ps
module triple_programmable_down_timer_tb_top;
	logic clk = 0, rst = 1, slow_clk = 0, wr_en = 0, rd_en = 0, irq;
	logic [7:0] addr = 0, wr_data = 0, rd_data, v;
	logic [2:0] tc_event;
	int mismatches, checks, n;
	triple_programmable_down_timer u_triple_programmable_down_timer (.*);
	always #20 clk = ~clk;
	always #15625 slow_clk = ~slow_clk;
	task chk(logic [7:0] s, logic [7:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	endtask
	function automatic logic [7:0] first_tc(logic [7:0] c);
		return c + 8'h03;
	endfunction
	function automatic logic [7:0] period(logic [7:0] c);
		return c + 8'h01;
	endfunction
	task wr(logic [7:0] a, logic [7:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1;
		@(posedge clk);
	endtask
	task rd(logic [7:0] a, logic [7:0] e);
		wr_en <= 0;
		addr <= a;
		rd_en <= 1;
		@(posedge clk);
		rd_en <= 0;
		@(negedge clk);
		chk(rd_data, e);
		@(posedge clk);
	endtask
	task wt(int i);
		n = 0;
		wr_en <= 0;
		do begin
			@(posedge clk);
			n++;
			if (n > 3000) begin
				mismatches++;
				close_out();
			end
		end while (tc_event[i] !== 1'b1);
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		v = 8'($urandom(4));
		repeat (20) @(posedge clk);
		rst <= 0;
		for (int a = 8'hb0; a < 8'hba; a++) rd(a[7:0], 8'h00);
		for (int t = 0; t < 3; t++) begin
			v = 8'($urandom);
			wr(8'hb1 + 8'(3 * t), v);
			rd(8'hb1 + 8'(3 * t), v);
			wr(8'hb2 + 8'(3 * t), ~v);
			rd(8'hb2 + 8'(3 * t), ~v);
			wr(8'hb0 + 8'(3 * t), v & 8'h06);
			rd(8'hb0 + 8'(3 * t), v & 8'h06);
		end
		v = 8'($urandom_range(40, 1));
		wr(8'hb1, 8'h00);
		wr(8'hb2, v);
		wr(8'hc1, 8'h01);
		wr(8'hb0, 8'h07);
		wt(0);
		chk(8'(n), first_tc(v));
		rd(8'hb0, 8'h06);
		chk({7'h00, irq}, 8'h01);
		wr(8'hc0, 8'h07);
		rd(8'hc0, 8'h00);
		chk({7'h00, irq}, 8'h00);
		wr(8'hc1, 8'h00);
		wr(8'hb4, 8'h00);
		wr(8'hb5, v);
		wr(8'hb3, 8'h05);
		wt(1);
		wt(1);
		chk(8'(n), period(v));
		wr(8'hb3, 8'h00);
		wr(8'hb7, 8'h00);
		wr(8'hb8, 8'h01);
		wr(8'hb6, 8'h03);
		wt(2);
		chk(8'(n > 700), 8'h01);
		close_out();
	end
endmodule
